// *** dv/mra_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mra_host_model (
	// clock
	input  wire logic                       clk,
	// register bus toward the device
	output logic                            stb,
	output logic [2:0]                      acc,
	output logic [mra_pkg::DATA_W-1:0]      din,
	// device answer
	input  wire logic [mra_pkg::DATA_W-1:0] dout
);
	int gap;

	// idle bus at time zero, back-to-back accesses by default
	initial begin
		stb = 1'b0;
		acc = 3'h0;
		din = 10'h000;
		gap = 0;
	end

	// one access, launched just after an edge and taken at the next one;
	// strobe stays up so calls run back to back, gap idles the bus first
	task automatic xfer(input logic [1:0] sel, input logic rd,
	                    input logic [9:0] d, output logic [9:0] q);
		if (gap > 0) begin
			stb <= 1'b0;
			din <= ~din; // a released bus must not keep the last value
			repeat (gap) @(posedge clk);
		end
		stb <= 1'b1;
		acc <= {sel, rd};
		din <= d;
		@(posedge clk);
		#1 q = dout;
	endtask

	// drop the strobe for one edge before the bench waits on its own
	task automatic idle();
		stb <= 1'b0;
		din <= ~din; // released bus shows the inverse
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// *** dv/mra_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module mra_port_tb;
	logic              ref_clk, srst, stb, oe, pr, lr;
	logic [2:0]        acc;
	logic [9:0]        din, dout, q;
	logic [7:0]        la, mask, c [4], p, v;
	logic [5:0]        fl;
	logic [2:0]        mf;
	mra_pkg::mra_rgb_t rgb, pal [4];
	int                err_count, checked, seed;
	int                n_pipe = 0;
	int                n_load = 0;

	initial ref_clk = 1'b0;
	always #12.5 ref_clk = ~ref_clk;

	mra_host_model u_mra_host_model (.clk(ref_clk), .stb(stb), .acc(acc),
		.din(din), .dout(dout));
	mra_port u_mra_port (.REF_CLK(ref_clk), .SRST(srst), .ACCESS_STB(stb),
		.ACCESS(acc), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe),
		.LOOKUP_ADDR(la), .LOOKUP_RGB(rgb), .PIXEL_MASK(mask),
		.MODE_NORMAL(mf[2]), .BUS_10BIT(mf[1]), .DAC_10BIT(mf[0]),
		.PIPELINE_RESET(pr), .LOAD_RESYNC(lr), .CAL_EVERY_VSYNC(fl[5]),
		.COLOR_24BIT(fl[4]), .PEDESTAL_ZERO_IRE(fl[3]),
		.SYNC_DISABLE(fl[2]), .MUX_TWO_TO_ONE(fl[1]), .PRGCLK_DIV8(fl[0]));

	// count one-cycle resync pulses
	always @(posedge ref_clk) begin
		n_pipe <= n_pipe + (pr === 1'b1);
		n_load <= n_load + (lr === 1'b1);
	end

	// command flags expected from the three command bytes
	function automatic logic [9:0] flags(input logic [7:0] a, b, d);
		return {4'h0, a[0], b[7], b[6], b[5], d[6], d[0]};
	endfunction

	task automatic chk(input logic [9:0] got, exp, input string m);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic wr(input logic [1:0] s, input logic [9:0] d);
		u_mra_host_model.xfer(s, 1'b0, d, q);
	endtask

	// read through the bus, device must drive it
	task automatic rd(input logic [1:0] s, input logic [9:0] e);
		u_mra_host_model.xfer(s, 1'b1, 10'h000, q);
		chk(q, e, "read data");
		chk({9'h0, oe}, 10'h001, "bus drive");
	endtask

	// set control register via pointer, read back twice
	task automatic ctl(input logic [7:0] a, d);
		wr(2'b00, {2'b00, a});
		wr(2'b10, {2'b00, d});
		chk({9'h0, oe}, 10'h000, "bus released");
		if (a >= 8'h04 && a <= 8'h07) c[a - 8'h04] = d;
		rd(2'b10, (a >= 8'h04 && a <= 8'h07) ? {2'b00, d} : 10'h000);
		rd(2'b10, (a >= 8'h04 && a <= 8'h07) ? {2'b00, d} : 10'h000);
		chk({2'b00, mask}, {2'b00, c[0]}, "mask out");
		chk({4'h0, fl}, flags(c[1], c[2], c[3]), "flags");
	endtask

	task automatic look(input logic [7:0] a, input mra_pkg::mra_rgb_t e);
		@(posedge ref_clk);
		la <= a;
		@(posedge ref_clk);
		#1 chk(rgb[29:20], e.red, "red");
		chk(rgb[19:10], e.green, "green");
		chk(rgb[9:0], e.blue, "blue");
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// cut a hang short
	initial begin
		#2000000;
		err_count++;
		final_report();
	end

	initial begin
		seed = 32'h5cc9736f;
		srst = 1'b1;
		la = 8'h00;
		err_count = 0;
		checked = 0;
		c = '{8'hFF, 8'h00, 8'h00, 8'h00};
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		chk({7'h0, mf}, 10'h007, "mode reset");
		rd(2'b00, 10'h000);
		$display("test reset done");
		// start-up string of mode writes, back to back
		foreach (c[i]) wr(2'b11, 10'h00F - {9'h0, i == 1} + {i == 2, 5'h0});
		wr(2'b11, 10'h00F);
		u_mra_host_model.idle();
		repeat (2) @(posedge ref_clk);
		chk(10'(n_pipe), 10'h001, "pipe pulse");
		chk(10'(n_load), 10'h001, "load pulse");
		rd(2'b11, 10'h00F);
		chk({7'h0, mf}, 10'h007, "mode out");
		$display("test mode done");
		ctl(8'h04, 8'hFF);
		ctl(8'h05, 8'h01);
		ctl(8'h06, 8'hE0);
		ctl(8'h07, 8'h41);
		ctl(8'h07, 8'h40);
		ctl(8'h08, 8'h5A);
		u_mra_host_model.gap = 2;
		repeat (12) begin
			p = 8'h04 + 8'($random(seed) & 3);
			v = 8'($random(seed));
			ctl(p, v);
		end
		u_mra_host_model.gap = 0;
		$display("test control done");
		// reset in mid-run: registers back to their reset values
		u_mra_host_model.idle();
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		#1 chk({9'h0, oe}, 10'h000, "bus after reset");
		rd(2'b00, 10'h000);
		chk({2'b00, mask}, 10'h0FF, "mask after reset");
		chk({4'h0, fl}, 10'h000, "flags after reset");
		chk({7'h0, mf}, 10'h007, "mode after reset");
		$display("test mid reset done");
		wr(2'b00, 10'h000);
		for (int i = 0; i < 3; i++) begin
			pal[i] = 30'($random(seed));
			wr(2'b01, pal[i].red);
			wr(2'b01, pal[i].green);
			wr(2'b01, pal[i].blue);
		end
		rd(2'b00, 10'h003);
		wr(2'b00, 10'h0FF);
		pal[3] = {3{10'h3FF}};
		for (int i = 0; i < 3; i++) wr(2'b01, 10'h3FF);
		rd(2'b00, 10'h000);
		// palette read-back steps the same component counter
		for (int i = 0; i < 3; i++) begin
			rd(2'b01, pal[i].red);
			rd(2'b01, pal[i].green);
			rd(2'b01, pal[i].blue);
		end
		rd(2'b00, 10'h003);
		u_mra_host_model.idle();
		for (int i = 0; i < 3; i++) look(8'(i), pal[i]);
		look(8'hFF, pal[3]);
		$display("test palette done");
		final_report();
	end
endmodule
`default_nettype wire

// *** src/mra_pkg.sv ***
// Functional notes
// R1: pointer loads with both selects low and write; 04H selects pixel mask.
// R2: pointer 06H selects command two, 07H selects command three.
// R3: pointer 00H written before palette accesses is the first palette location.
// R4: select high=1, low=0, write stores byte into pointed register; FFH sets mask.
// R5: both selects high with write loads mode register; 0FH means normal, 10-bit.
// R6: pipeline reset bit written 1,0,1 resets the colour input pipelines.
// R7: load sync bit written 0,1,0 resynchronises pixel load timing.
// R8: command one written 01H enables calibration every vertical sync.
// R9: command two written E0H selects 24-bit colour, zero pedestal, no sync.
// R10: command three 41H selects 2:1 mux and clock out at pixel clock/8.
// R11: palette writes use selects 0,1: red, green, blue 10-bit words per location.
// R12: select high=1, low=0, read drives the pointed register onto the bus.
// R13: a control register reads back at once and repeatedly without reloading.
// R14: after each blue palette write the location advances by one.
package mra_pkg;

	// sizes
	localparam int PTR_W     = 8;
	localparam int CTL_W     = 8;
	localparam int DATA_W    = 10;
	localparam int PAL_DEPTH = 256;
	localparam int CTL_COUNT = 4;

	// pointer offsets of the palette base and the indirect control registers
	localparam logic [7:0] OFF_PALETTE_BASE = 8'h00;
	localparam logic [7:0] OFF_PIXEL_MASK   = 8'h04;
	localparam logic [7:0] OFF_CMD_ONE      = 8'h05;
	localparam logic [7:0] OFF_CMD_TWO      = 8'h06;
	localparam logic [7:0] OFF_CMD_THREE    = 8'h07;

	// reset values, indexed from the pixel mask upward
	localparam logic [7:0] CTL_RESET [0:CTL_COUNT-1] =
		'{8'hFF, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] MODE_RESET  = 8'h0F;
	localparam logic [7:0] PTR_RESET   = 8'h00;

	// mode register fields
	localparam int MODE_PIPE_RST_BIT  = 0;
	localparam int MODE_DAC10_BIT     = 1;
	localparam int MODE_BUS10_BIT     = 2;
	localparam int MODE_NORMAL_BIT    = 3;
	localparam int MODE_LOAD_SYNC_BIT = 5;

	// command register fields
	localparam int CMD1_CAL_VSYNC_BIT  = 0;
	localparam int CMD2_COLOR24_BIT    = 7;
	localparam int CMD2_ZERO_IRE_BIT   = 6;
	localparam int CMD2_NO_SYNC_BIT    = 5;
	localparam int CMD3_MUX21_BIT      = 6;
	localparam int CMD3_PRGCK_DIV8_BIT = 0;

	// write histories that trigger the resynchronising actions
	localparam logic [2:0] PIPE_RST_SEQ  = 3'h5;
	localparam logic [2:0] LOAD_SYNC_SEQ = 3'h2;

	// port selected by the two register-select lines (high, low)
	typedef enum logic [1:0] {
		ACC_POINTER,
		ACC_PALETTE,
		ACC_CONTROL,
		ACC_MODE
	} mra_port_t;

	// colour component currently addressed in a palette location
	typedef enum logic [1:0] {
		COMP_RED,
		COMP_GREEN,
		COMP_BLUE
	} mra_comp_t;

	typedef struct packed {
		logic sel_high;
		logic sel_low;
		logic read;
	} mra_access_t;

	typedef struct packed {
		logic [DATA_W-1:0] red;
		logic [DATA_W-1:0] green;
		logic [DATA_W-1:0] blue;
	} mra_rgb_t;

endpackage

// *** src/mra_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module mra_port (
	// clock and reset
	input  wire logic                         REF_CLK,
	input  wire logic                         SRST,
	// host register bus
	input  wire logic                         ACCESS_STB,
	input  wire mra_pkg::mra_access_t         ACCESS,
	input  wire logic [mra_pkg::DATA_W-1:0]   DATA_IN,
	output logic      [mra_pkg::DATA_W-1:0]   DATA_OUT,
	output logic                              DATA_OE,
	// palette lookup from the pixel side
	input  wire logic [mra_pkg::PTR_W-1:0]    LOOKUP_ADDR,
	output mra_pkg::mra_rgb_t                 LOOKUP_RGB,
	output logic      [mra_pkg::CTL_W-1:0]    PIXEL_MASK,
	// mode controls
	output logic                              MODE_NORMAL,
	output logic                              BUS_10BIT,
	output logic                              DAC_10BIT,
	output logic                              PIPELINE_RESET,
	output logic                              LOAD_RESYNC,
	// command controls
	output logic                              CAL_EVERY_VSYNC,
	output logic                              COLOR_24BIT,
	output logic                              PEDESTAL_ZERO_IRE,
	output logic                              SYNC_DISABLE,
	output logic                              MUX_TWO_TO_ONE,
	output logic                              PRGCLK_DIV8
);

	// true when the pointer lands on one of the control registers
	function automatic logic ctl_hit(input logic [7:0] ptr);
		ctl_hit = (ptr >= mra_pkg::OFF_PIXEL_MASK) &&
			(ptr <= mra_pkg::OFF_CMD_THREE);
	endfunction

	logic [7:0]          pointer;
	logic [7:0]          mode;
	logic [7:0]          ctl [0:mra_pkg::CTL_COUNT-1];
	mra_pkg::mra_rgb_t   pal [0:mra_pkg::PAL_DEPTH-1];
	mra_pkg::mra_comp_t  comp;
	mra_pkg::mra_comp_t  next_comp;
	logic [9:0]          red_stage;
	logic [9:0]          green_stage;
	logic [9:0]          next_data;

	wire mra_pkg::mra_port_t port_sel;
	wire        wr;
	wire        rd;
	wire        wr_ptr;
	wire        wr_pal;
	wire        wr_ctl;
	wire        wr_mode;
	wire        rd_pal;
	wire        pal_step;
	wire        ctl_ok;
	wire [7:0]  ptr_off;
	wire [1:0]  ctl_idx;
	wire [9:0]  ctl_rd_val;
	wire [9:0]  pal_rd_val;
	wire mra_pkg::mra_rgb_t pal_cur;

	// access decode from the two select lines and the read line
	assign port_sel = mra_pkg::mra_port_t'({ACCESS.sel_high, ACCESS.sel_low});
	assign wr       = ACCESS_STB && !ACCESS.read;
	assign rd       = ACCESS_STB && ACCESS.read;
	assign wr_ptr   = wr && (port_sel == mra_pkg::ACC_POINTER); // R1
	assign wr_pal   = wr && (port_sel == mra_pkg::ACC_PALETTE); // R11
	assign wr_ctl   = wr && (port_sel == mra_pkg::ACC_CONTROL); // R4
	assign wr_mode  = wr && (port_sel == mra_pkg::ACC_MODE); // R5
	assign rd_pal   = rd && (port_sel == mra_pkg::ACC_PALETTE);
	assign pal_step = wr_pal || rd_pal;

	// pointer decode for the control registers, 04H to 07H
	assign ctl_ok  = ctl_hit(pointer); // R1 R2
	assign ptr_off = pointer - mra_pkg::OFF_PIXEL_MASK;
	assign ctl_idx = ptr_off[1:0];

	// read-back values; unmapped pointers read as zero
	assign ctl_rd_val = ctl_ok ? {2'h0, ctl[ctl_idx]} : 10'h000; // R12 R13
	assign pal_cur    = pal[pointer];
	assign pal_rd_val = (comp == mra_pkg::COMP_RED)   ? pal_cur.red :
	                    (comp == mra_pkg::COMP_GREEN) ? pal_cur.green :
	                                                    pal_cur.blue;

	// component sequence red, green, blue, then wrap to the next location
	always_comb begin
		case (comp)
			mra_pkg::COMP_RED:   next_comp = mra_pkg::COMP_GREEN;
			mra_pkg::COMP_GREEN: next_comp = mra_pkg::COMP_BLUE;
			default:             next_comp = mra_pkg::COMP_RED;
		endcase
	end

	// read data selection by port
	always_comb begin
		case (port_sel)
			mra_pkg::ACC_POINTER: next_data = {2'h0, pointer};
			mra_pkg::ACC_PALETTE: next_data = pal_rd_val;
			mra_pkg::ACC_CONTROL: next_data = ctl_rd_val; // R12
			default:              next_data = {2'h0, mode};
		endcase
	end

	// pointer and palette component tracking
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			pointer <= mra_pkg::PTR_RESET;
			comp    <= mra_pkg::COMP_RED;
		end else if (wr_ptr) begin
			pointer <= DATA_IN[7:0]; // R1 R3
			comp    <= mra_pkg::COMP_RED; // R3
		end else if (pal_step) begin
			comp <= next_comp;
			if (comp == mra_pkg::COMP_BLUE)
				pointer <= pointer + 8'h01; // R14
		end
	end

	// staging keeps a location unchanged until its blue word arrives
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			red_stage   <= 10'h000;
			green_stage <= 10'h000;
		end else if (wr_pal && comp == mra_pkg::COMP_RED) begin
			red_stage <= DATA_IN; // R11
		end else if (wr_pal && comp == mra_pkg::COMP_GREEN) begin
			green_stage <= DATA_IN; // R11
		end
	end

	// palette storage; no reset, contents are undefined until loaded
	always_ff @(posedge REF_CLK) begin
		if (wr_pal && comp == mra_pkg::COMP_BLUE)
			pal[pointer] <= {red_stage, green_stage, DATA_IN}; // R11
	end

	// control registers addressed through the pointer
	for (genvar i = 0; i < mra_pkg::CTL_COUNT; i++) begin : g_ctl
		always_ff @(posedge REF_CLK) begin
			if (SRST)
				ctl[i] <= mra_pkg::CTL_RESET[i];
			else if (wr_ctl && ctl_ok && ctl_idx == 2'(i))
				ctl[i] <= DATA_IN[7:0]; // R4 R2
		end
	end

	// mode register is written directly, no pointer involved
	always_ff @(posedge REF_CLK) begin
		if (SRST)
			mode <= mra_pkg::MODE_RESET;
		else if (wr_mode)
			mode <= DATA_IN[7:0]; // R5
	end

	// read answer registered; bus driven until the next write
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			DATA_OUT <= 10'h000;
			DATA_OE  <= 1'b0;
		end else if (rd) begin
			DATA_OUT <= next_data; // R12 R13
			DATA_OE  <= 1'b1;
		end else if (wr) begin
			DATA_OE <= 1'b0;
		end
	end

	// palette lookup for the pixel side
	always_ff @(posedge REF_CLK) begin
		if (SRST)
			LOOKUP_RGB <= '0;
		else
			LOOKUP_RGB <= pal[LOOKUP_ADDR];
	end

	// bit sequences on the mode register, one detector each
	mra_seq_detect #(.PATTERN(mra_pkg::PIPE_RST_SEQ)) u_pipe_rst (
		.clk       (REF_CLK),
		.srst      (SRST),
		.write_stb (wr_mode),
		.bit_val   (DATA_IN[mra_pkg::MODE_PIPE_RST_BIT]), // R6
		.hit       (PIPELINE_RESET)
	);

	mra_seq_detect #(.PATTERN(mra_pkg::LOAD_SYNC_SEQ)) u_load_sync (
		.clk       (REF_CLK),
		.srst      (SRST),
		.write_stb (wr_mode),
		.bit_val   (DATA_IN[mra_pkg::MODE_LOAD_SYNC_BIT]), // R7
		.hit       (LOAD_RESYNC)
	);

	// control fields straight from the stored registers
	assign PIXEL_MASK        = ctl[0];
	assign MODE_NORMAL       = mode[mra_pkg::MODE_NORMAL_BIT]; // R5
	assign BUS_10BIT         = mode[mra_pkg::MODE_BUS10_BIT];
	assign DAC_10BIT         = mode[mra_pkg::MODE_DAC10_BIT];
	assign CAL_EVERY_VSYNC   = ctl[1][mra_pkg::CMD1_CAL_VSYNC_BIT]; // R8
	assign COLOR_24BIT       = ctl[2][mra_pkg::CMD2_COLOR24_BIT]; // R9
	assign PEDESTAL_ZERO_IRE = ctl[2][mra_pkg::CMD2_ZERO_IRE_BIT];
	assign SYNC_DISABLE      = ctl[2][mra_pkg::CMD2_NO_SYNC_BIT];
	assign MUX_TWO_TO_ONE    = ctl[3][mra_pkg::CMD3_MUX21_BIT]; // R10
	assign PRGCLK_DIV8       = ctl[3][mra_pkg::CMD3_PRGCK_DIV8_BIT];

	a_ptr_load: assert property (@(posedge REF_CLK) disable iff (SRST) // R1
		wr_ptr |=> pointer == $past(DATA_IN[7:0]) && comp == mra_pkg::COMP_RED)
		else $error("pointer write not taken");

	a_mask_store: assert property (@(posedge REF_CLK) disable iff (SRST) // R4
		wr_ctl && pointer == mra_pkg::OFF_PIXEL_MASK
		|=> PIXEL_MASK == $past(DATA_IN[7:0]))
		else $error("pixel mask write not stored");

	a_cmd_two_dec: assert property (@(posedge REF_CLK) disable iff (SRST) // R9
		wr_ctl && pointer == mra_pkg::OFF_CMD_TWO && DATA_IN[7:0] == 8'hE0
		|=> COLOR_24BIT && PEDESTAL_ZERO_IRE && SYNC_DISABLE
			&& !MUX_TWO_TO_ONE == $past(!MUX_TWO_TO_ONE))
		else $error("command two E0 not decoded");

	a_cmd_three_dec: assert property (@(posedge REF_CLK) disable iff (SRST) // R10
		wr_ctl && pointer == mra_pkg::OFF_CMD_THREE && DATA_IN[7:0] == 8'h41
		|=> MUX_TWO_TO_ONE && PRGCLK_DIV8)
		else $error("command three 41 not decoded");

	a_cmd_one_cal: assert property (@(posedge REF_CLK) disable iff (SRST) // R8
		wr_ctl && pointer == mra_pkg::OFF_CMD_ONE && DATA_IN[7:0] == 8'h01
		|=> CAL_EVERY_VSYNC)
		else $error("command one 01 not decoded");

	a_mode_normal: assert property (@(posedge REF_CLK) disable iff (SRST) // R5
		wr_mode && DATA_IN[7:0] == 8'h0F
		|=> MODE_NORMAL && BUS_10BIT && DAC_10BIT)
		else $error("mode 0F not decoded");

	a_ctl_readback: assert property (@(posedge REF_CLK) disable iff (SRST) // R13
		wr_ctl && ctl_ok ##1 rd && port_sel == mra_pkg::ACC_CONTROL
		|=> DATA_OE && DATA_OUT == {2'h0, $past(DATA_IN[7:0], 2)})
		else $error("control read-back differs from written value");

	a_pal_advance: assert property (@(posedge REF_CLK) disable iff (SRST) // R14
		wr_pal && comp == mra_pkg::COMP_BLUE
		|=> pointer == $past(pointer) + 8'h01 && comp == mra_pkg::COMP_RED)
		else $error("palette location did not advance after blue");

endmodule
`default_nettype wire

// *** src/mra_seq_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
module mra_seq_detect #(
	parameter logic [2:0] PATTERN = 3'h5
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// written bit
	input  wire logic write_stb,
	input  wire logic bit_val,
	// one-cycle pulse after the matching write
	output logic      hit
);

	logic [2:0] hist;
	logic [1:0] fill;
	logic [2:0] next_hist;
	logic       full;

	// history only counts once three writes have been seen
	assign next_hist = {hist[1:0], bit_val};
	assign full      = (fill >= 2'h2);

	// shift on every write of the watched register
	always_ff @(posedge clk) begin
		if (srst) begin
			hist <= 3'h0;
			fill <= 2'h0;
			hit  <= 1'b0;
		end else begin
			hit <= write_stb && full && (next_hist == PATTERN);
			if (write_stb) begin
				hist <= next_hist;
				if (!full)
					fill <= fill + 2'h1;
			end
		end
	end

	a_seq_hit_cause: assert property (@(posedge clk) disable iff (srst)
		hit |-> $past(write_stb) && ($past(hist[1:0]) == PATTERN[2:1])
			&& ($past(bit_val) == PATTERN[0])) // R6
		else $error("sequence pulse without matching write history");

	a_seq_hit_pulse: assert property (@(posedge clk) disable iff (srst)
		write_stb && full && (next_hist == PATTERN) |=> hit) // R7
		else $error("matching write history gave no pulse");

endmodule
`default_nettype wire
